// ### core/accumulator_rotate_round_unit.sv
// Execution unit for rotate through carry, carry set and rounding call.
`timescale 1ns/1ns
`default_nettype none
module accumulator_rotate_round_unit
    import rotate_unit_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 op_valid,
    input  wire op_code_t             op_code,
    input  wire acc_sel_t             op_acc,
    input  wire logic                 op_has_count,
    input  wire logic [COUNT_W-1:0]   op_count,
    input  wire logic [DATA_W-1:0]    round_const,
    output logic                      op_ready,
    output logic [1:0]                op_length,
    output logic                      round_call,
    output logic [DATA_W-1:0]         round_const_out,
    output logic [DATA_W-1:0]         acc_x,
    output logic [DATA_W-1:0]         acc_y,
    output logic [DATA_W-1:0]         acc_z,
    output logic [DATA_W-1:0]         acc_r,
    output logic                      flag_carry,
    output logic                      flag_overflow,
    output logic                      flag_sign,
    output logic                      flag_zero,
    output logic                      done
);
    logic [DATA_W-1:0]  acc_q [4];
    logic               c_q, o_q, s_q, z_q;
    state_t             state_q;
    logic [COUNT_W-1:0] left_q;
    logic               dir_left_q;
    acc_sel_t           sel_q;
    logic               done_q, call_q;
    logic [DATA_W-1:0]  const_q;

    // One rotate step through carry on the accumulator currently addressed.
    logic              step_left;
    acc_sel_t          step_sel;
    logic [DATA_W-1:0] step_in, step_out;
    logic              step_c;
    logic              start_rot, do_step;

    assign start_rot = op_valid && op_ready &&
                       (op_code == OP_ROTATE_LEFT || op_code == OP_ROTATE_RIGHT);
    assign step_left = (state_q == ST_REPEAT) ? dir_left_q : (op_code == OP_ROTATE_LEFT);
    assign step_sel  = (state_q == ST_REPEAT) ? sel_q : op_acc;
    assign step_in   = acc_q[step_sel];
    // A counted rotate spends its accept cycle on the count byte and steps only afterwards,
    // which costs one cycle more than the bare steps but keeps the count off the data path.
    assign do_step   = (state_q == ST_REPEAT) || (start_rot && !op_has_count);

    always_comb begin
        if (step_left) begin
            step_out = {step_in[DATA_W-2:0], c_q};
            step_c   = step_in[DATA_W-1];
        end else begin
            step_out = {c_q, step_in[DATA_W-1:1]};
            step_c   = step_in[0];
        end
    end

    // New instructions are accepted only while no repeated rotate is running.
    assign op_ready  = (state_q == ST_IDLE);
    assign op_length = (op_code == OP_ROUND || ((op_code == OP_ROTATE_LEFT ||
                        op_code == OP_ROTATE_RIGHT) && op_has_count)) ?
                        2'(LEN_LONG) : 2'(LEN_SHORT);

    // Sequencer for repeated rotates; each step costs one further cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            left_q     <= '0;
            dir_left_q <= 1'b0;
            sel_q      <= ACC_X;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Every counted rotate enters the repeat state, so it takes one plus count.
                    // A count of zero is treated as one step so the instruction is never empty.
                    if (start_rot && op_has_count) begin
                        state_q    <= ST_REPEAT;
                        left_q     <= (op_count == '0) ? COUNT_W'(1) : op_count;
                        dir_left_q <= (op_code == OP_ROTATE_LEFT);
                        sel_q      <= op_acc;
                    end
                end
                ST_REPEAT: begin
                    left_q <= left_q - COUNT_W'(1);
                    if (left_q == COUNT_W'(1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Accumulator file; the rotate writes back every step.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= ACC_RESET;
            end
        end else if (do_step) begin
            acc_q[step_sel] <= step_out;
        end
    end

    // Flags are overwritten every step, so after a repeat only the last step shows.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            c_q <= 1'b0;
            o_q <= 1'b0;
            s_q <= 1'b0;
            z_q <= 1'b0;
        end else if (do_step) begin
            c_q <= step_c;
            o_q <= step_out[DATA_W-1] ^ step_in[DATA_W-1];
            s_q <= step_out[DATA_W-1];
            z_q <= (step_out == '0);
        end else if (op_valid && op_ready && op_code == OP_SET_CARRY) begin
            c_q <= 1'b1;
            o_q <= 1'b0;
        end
    end

    // Completion pulse and the rounding subroutine call request.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_q  <= 1'b0;
            call_q  <= 1'b0;
            const_q <= '0;
        end else begin
            done_q <= (op_valid && op_ready && op_code != OP_NONE &&
                       !(start_rot && op_has_count)) ||
                      (state_q == ST_REPEAT && left_q == COUNT_W'(1));
            call_q <= op_valid && op_ready && op_code == OP_ROUND;
            if (op_valid && op_ready && op_code == OP_ROUND) begin
                // The subroutine rounds x, down below five and up from five.
                const_q <= round_const;
            end
        end
    end

    // Outputs other than op_ready and op_length come straight from flip-flops, so the register side never sees a glitch.
    assign acc_x           = acc_q[ACC_X];
    assign acc_y           = acc_q[ACC_Y];
    assign acc_z           = acc_q[ACC_Z];
    assign acc_r           = acc_q[ACC_R];
    assign flag_carry      = c_q;
    assign flag_overflow   = o_q;
    assign flag_sign       = s_q;
    assign flag_zero       = z_q;
    assign done            = done_q;
    assign round_call      = call_q;
    assign round_const_out = const_q;

    // Checks on the unit's own state and outputs; each names the rule that it guards.
    a_left_step: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_code == OP_ROTATE_LEFT && !op_has_count) |=>
        acc_q[$past(op_acc)] == {$past(step_in[DATA_W-2:0]), $past(c_q)})
        else $error("Left rotate result wrong.");
    a_left_carry: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_code == OP_ROTATE_LEFT && !op_has_count) |=>
        c_q == $past(step_in[DATA_W-1]))
        else $error("Left rotate carry wrong.");
    a_right_carry: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_code == OP_ROTATE_RIGHT && !op_has_count) |=> c_q == $past(step_in[0]))
        else $error("Right rotate carry wrong.");
    a_right_repeat: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == ST_REPEAT && !dir_left_q) |=> c_q == $past(step_in[0]))
        else $error("Repeated right rotate carry wrong.");
    a_right_fill: assert property (@(posedge clk_sys) disable iff (rst)
        (do_step && !step_left) |=> acc_q[$past(step_sel)][DATA_W-1] == $past(c_q))
        else $error("Right rotate fill wrong.");
    a_repeat_len: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_has_count && op_count == 4'h3) |=> !op_ready [*3] ##1 op_ready)
        else $error("Repeat length wrong.");
    a_done_count: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_has_count && op_count == 4'h2) |=> !done ##1 !done ##1 done)
        else $error("Counted rotate done at wrong cycle.");
    a_single_done: assert property (@(posedge clk_sys) disable iff (rst)
        (op_valid && op_ready && op_code != OP_NONE && !(start_rot && op_has_count)) |=> done)
        else $error("Single cycle instruction not done.");
    a_count_accept: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_has_count) |=> $stable(acc_x) && $stable(acc_y) &&
        $stable(acc_z) && $stable(acc_r))
        else $error("Accept cycle of counted rotate changed data.");
    a_repeat_start: assert property (@(posedge clk_sys) disable iff (rst)
        (start_rot && op_has_count) |=> state_q == ST_REPEAT)
        else $error("Repeat not started.");
    a_busy_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == ST_REPEAT) |-> !op_ready && !done)
        else $error("Busy unit accepts or completes.");
    a_flag_last: assert property (@(posedge clk_sys) disable iff (rst)
        do_step |=> (z_q == (acc_q[$past(step_sel)] == '0)) &&
        s_q == acc_q[$past(step_sel)][DATA_W-1])
        else $error("Flags not from last step.");
    a_set_carry: assert property (@(posedge clk_sys) disable iff (rst)
        (op_valid && op_ready && op_code == OP_SET_CARRY) |=> c_q && !o_q && $stable(z_q) && done)
        else $error("Carry set wrong.");
    a_set_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        (op_valid && op_ready && op_code == OP_SET_CARRY) |=> $stable(s_q) && $stable(acc_x))
        else $error("Carry set touched other state.");
    a_round_call: assert property (@(posedge clk_sys) disable iff (rst)
        (op_valid && op_ready && op_code == OP_ROUND) |=>
        round_call && const_q == $past(round_const))
        else $error("Round call missing.");
    a_length_code: assert property (@(posedge clk_sys) disable iff (rst)
        (op_code == OP_ROTATE_LEFT && !op_has_count) |-> op_length == 2'h1)
        else $error("Rotate length wrong.");
endmodule : accumulator_rotate_round_unit
`default_nettype wire

// ### core/rotate_unit_pkg.sv
// Package with encodings, widths and timing constants of the rotate and round unit.
package rotate_unit_pkg;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned COUNT_W       = 4;
    localparam int unsigned LEN_SHORT     = 1;
    localparam int unsigned LEN_LONG      = 2;
    localparam int unsigned SINGLE_CYCLES = 1;
    localparam int unsigned ROUND_LIMIT   = 5;
    localparam logic [DATA_W-1:0] ACC_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {ACC_X, ACC_Y, ACC_Z, ACC_R} acc_sel_t;
    typedef enum logic [2:0] {OP_NONE, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_SET_CARRY,
                              OP_ROUND} op_code_t;
    typedef enum {ST_IDLE, ST_REPEAT} state_t;
endpackage : rotate_unit_pkg

// ### dv/accumulator_rotate_round_unit_tb.sv
// Self-checking bench of the rotate and round unit.
`timescale 1ns/1ns
`default_nettype none
module accumulator_rotate_round_unit_tb;
    import rotate_unit_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    // Instruction fields are driven only by the decoder model.
    logic op_valid, op_has_count, op_ready, round_call, done;
    op_code_t op_code;
    acc_sel_t op_acc;
    logic [COUNT_W-1:0] op_count;
    logic [DATA_W-1:0] round_const, round_const_out, acc_x, acc_y, acc_z, acc_r;
    logic [1:0] op_length;
    logic flag_carry, flag_overflow, flag_sign, flag_zero;
    int fails = 0, compares = 0, cycles = 0, cyc;
    accumulator_rotate_round_unit u_accumulator_rotate_round_unit (.*);
    rotate_op_source u_rotate_op_source (.*);
    // Free-running 100 ns clock.
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    function automatic logic [31:0] fl();
        return {28'h0, flag_carry, flag_overflow, flag_sign, flag_zero};
    endfunction : fl
    task automatic op(op_code_t c, acc_sel_t a, logic hc, int n);
        u_rotate_op_source.run(c, a, hc, 4'(n), 32'h0000_0005, cyc);
    endtask : op
    task automatic sc_set_carry();
        op(OP_SET_CARRY, ACC_X, 1'b0, 0);
        chk(fl(), 32'h8);
        chk(32'(cyc), 32'h1);
        chk(u_rotate_op_source.len_seen, 32'h1);
    endtask : sc_set_carry
    task automatic sc_left_single();
        op(OP_ROTATE_LEFT, ACC_X, 1'b0, 0);
        chk(acc_x, 32'h1);
        chk(fl(), 32'h0);
        chk(32'(cyc), 32'h1);
        chk(u_rotate_op_source.len_seen, 32'h1);
        op(OP_ROTATE_LEFT, ACC_R, 1'b0, 0);
        chk(fl(), 32'h1);
    endtask : sc_left_single
    task automatic sc_left_count();
        op(OP_SET_CARRY, ACC_X, 1'b0, 0);
        op(OP_ROTATE_LEFT, ACC_X, 1'b1, 3);
        chk(acc_x, 32'hc);
        chk(fl(), 32'h0);
        chk(32'(cyc), 32'h4);
        chk(u_rotate_op_source.len_seen, 32'h2);
        // A count of one still costs the accept cycle plus one step.
        op(OP_SET_CARRY, ACC_X, 1'b0, 0);
        op(OP_ROTATE_LEFT, ACC_Z, 1'b1, 1);
        chk(acc_z, 32'h1);
        chk(fl(), 32'h0);
        chk(32'(cyc), 32'h2);
    endtask : sc_left_count
    task automatic sc_right();
        op(OP_SET_CARRY, ACC_X, 1'b0, 0);
        op(OP_ROTATE_RIGHT, ACC_Y, 1'b0, 0);
        chk(acc_y, 32'h8000_0000);
        chk(fl(), 32'h6);
        // Four steps of 0xc: the low set bit passes through carry onto the top, the high one ends in carry.
        op(OP_ROTATE_RIGHT, ACC_X, 1'b1, 4);
        chk(acc_x, 32'h8000_0000);
        chk(fl(), 32'he);
        chk(acc_y, 32'h8000_0000);
        chk(32'(cyc), 32'h5);
    endtask : sc_right
    task automatic sc_round();
        op(OP_ROUND, ACC_X, 1'b0, 0);
        chk(32'(round_call), 32'h1);
        chk(round_const_out, 32'h5);
    endtask : sc_round
    // Hang guard: the whole run needs well under this many cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end
    // Main sequence: reset for eight cycles, then every scenario in turn.
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        sc_set_carry();
        sc_left_single();
        sc_left_count();
        sc_right();
        sc_round();
        end_sim();
    end
endmodule : accumulator_rotate_round_unit_tb
`default_nettype wire

// ### dv/rotate_op_source.sv
// Model of the decoder side that issues one instruction at a time.
`timescale 1ns/1ns
`default_nettype none
module rotate_op_source
    import rotate_unit_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               op_ready,
    input  wire logic               done,
    input  wire logic [1:0]         op_length,
    output var  logic               op_valid,
    output var  op_code_t           op_code,
    output var  acc_sel_t           op_acc,
    output var  logic               op_has_count,
    output var  logic [COUNT_W-1:0] op_count,
    output var  logic [DATA_W-1:0]  round_const
);
    logic [1:0] len_seen;
    // Idle values until the first instruction is issued.
    initial begin
        op_valid     = 1'b0;
        op_code      = OP_NONE;
        op_acc       = ACC_X;
        op_has_count = 1'b0;
        op_count     = 4'h0;
        round_const  = 32'h0000_0000;
        len_seen     = 2'h0;
    end
    // Fields are held from a falling edge past the taking edge; at the next falling edge count and constant are inverted.
    task automatic run(input op_code_t c, input acc_sel_t a, input logic hc,
                       input logic [COUNT_W-1:0] n, input logic [DATA_W-1:0] k,
                       output int cyc);
        @(negedge clk_sys);
        while (op_ready !== 1'b1) @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = c;
        op_acc = a;
        op_has_count = hc;
        op_count = n;
        round_const = k;
        #1 len_seen = op_length;
        @(posedge clk_sys);
        @(negedge clk_sys);
        op_valid = 1'b0;
        op_code = OP_NONE;
        op_count = ~op_count;
        round_const = ~round_const;
        cyc = 1;
        while (done !== 1'b1 && cyc < 40) begin
            @(negedge clk_sys);
            cyc++;
        end
    endtask : run
endmodule : rotate_op_source
`default_nettype wire
